// File: hdl/pcr_regs.sv
// pcr_regs: host-visible port and control register block
// assumes host strobes are synchronous to clk; pins and array signals come from outside
`timescale 1ns/1ps
module pcr_regs #(
  parameter bit BOOT_FITTED = 1'b1,
  parameter bit SRAM_FITTED = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // host register access
  input wire logic register_window_select,
  input wire logic [7:0] addr,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  // port pins
  input wire logic [7:0] pa_in,
  input wire logic [7:0] pb_in,
  input wire logic [7:0] pc_in,
  input wire logic [7:0] pd_in,
  output logic [7:0] pa_out,
  output logic [7:0] pb_out,
  output logic [7:0] pc_out,
  output logic [7:0] pd_out,
  output logic [7:0] pa_oe,
  output logic [7:0] pb_oe,
  output logic [7:0] pc_oe,
  output logic [7:0] pd_oe,
  output logic [7:0] pa_pad,
  output logic [7:0] pb_pad,
  output logic [7:0] pc_pad,
  output logic [7:0] pd_pad,
  // latched address for A and B
  input wire logic [7:0] latched_addr_a,
  input wire logic [7:0] latched_addr_b,
  // logic array side
  input wire logic [7:0] input_cells_a,
  input wire logic [7:0] input_cells_b,
  input wire logic [7:0] input_cells_c,
  input wire logic [7:0] cells_ab_next_in,
  input wire logic [7:0] cells_bc_next_in,
  input wire logic [7:0] cells_ab_oe,
  input wire logic [7:0] cells_bc_oe,
  output logic [7:0] cells_ab,
  output logic [7:0] cells_bc,
  // memory selects from decode array
  input wire logic [7:0] main_sector_selects_in,
  input wire logic [3:0] boot_sector_selects_in,
  input wire logic sram_block_select_in,
  output logic [7:0] main_sector_selects,
  output logic [3:0] boot_sector_selects,
  output logic sram_block_select,
  // flash lock state
  input wire logic [7:0] main_lock_in,
  input wire logic [3:0] boot_lock_in,
  input wire logic security_in,
  // control outputs
  output logic [7:0] power_first,
  output logic [7:0] power_second,
  output logic [7:0] scan_port,
  output logic [7:0] page,
  output logic [7:0] space_map
);
  logic [7:0] pin_s1 [4];
  logic [7:0] pin_s2 [4];
  logic [7:0] pin_s3 [4];
  logic [7:0] pin_now [4];
  logic [7:0] a_mode;
  logic [7:0] b_mode;
  logic [7:0] out_r [4];
  logic [7:0] dir_r [4];
  logic [7:0] pad_r [4];
  logic [7:0] mask_ab;
  logic [7:0] mask_bc;
  logic [7:0] next_cells_ab;
  logic [7:0] next_cells_bc;
  wire [7:0] pin_raw [4];
  wire acc_wr;
  wire [7:0] mux_rd;
  wire [7:0] a_oe_eff;
  wire [7:0] b_oe_eff;
  wire [7:0] c_oe_eff;
  wire [7:0] d_oe_eff;
  wire we_a_mode;
  wire we_b_mode;
  wire we_a_out;
  wire we_b_out;
  wire we_c_out;
  wire we_d_out;
  wire we_a_dir;
  wire we_b_dir;
  wire we_c_dir;
  wire we_d_dir;
  wire we_a_pad;
  wire we_b_pad;
  wire we_c_pad;
  wire we_d_pad;
  wire we_mask_ab;
  wire we_mask_bc;
  wire we_pwr_first;
  wire we_pwr_second;
  wire we_scan;
  wire we_page;
  wire we_space;
  wire we_cells_ab;
  wire we_cells_bc;

  assign pin_raw[0] = pa_in;
  assign pin_raw[1] = pb_in;
  assign pin_raw[2] = pc_in;
  assign pin_raw[3] = pd_in;

  // three-stage pin sampling, change accepted when stages 2 and 3 agree
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_pin
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
        begin
          pin_s1[g] <= pcr_pkg::RST_REG;
          pin_s2[g] <= pcr_pkg::RST_REG;
          pin_s3[g] <= pcr_pkg::RST_REG;
          pin_now[g] <= pcr_pkg::RST_REG;
        end
        else
        begin
          pin_s1[g] <= pin_raw[g];
          pin_s2[g] <= pin_s1[g];
          pin_s3[g] <= pin_s2[g];
          pin_now[g] <= (pin_s2[g] & pin_s3[g]) | (pin_now[g] & (pin_s2[g] | pin_s3[g]));
        end
      end
    end
  endgenerate

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  assign acc_wr = register_window_select & wr_stb;

  // write enables, one per listed writable offset
  assign we_a_mode = acc_wr && hit(addr, pcr_pkg::OFF_A_MODE);
  assign we_b_mode = acc_wr && hit(addr, pcr_pkg::OFF_B_MODE);
  assign we_a_out = acc_wr && hit(addr, pcr_pkg::OFF_A_OUT);
  assign we_b_out = acc_wr && hit(addr, pcr_pkg::OFF_B_OUT);
  assign we_c_out = acc_wr && hit(addr, pcr_pkg::OFF_C_OUT);
  assign we_d_out = acc_wr && hit(addr, pcr_pkg::OFF_D_OUT);
  assign we_a_dir = acc_wr && hit(addr, pcr_pkg::OFF_A_DIR);
  assign we_b_dir = acc_wr && hit(addr, pcr_pkg::OFF_B_DIR);
  assign we_c_dir = acc_wr && hit(addr, pcr_pkg::OFF_C_DIR);
  assign we_d_dir = acc_wr && hit(addr, pcr_pkg::OFF_D_DIR);
  assign we_a_pad = acc_wr && hit(addr, pcr_pkg::OFF_A_PAD);
  assign we_b_pad = acc_wr && hit(addr, pcr_pkg::OFF_B_PAD);
  assign we_c_pad = acc_wr && hit(addr, pcr_pkg::OFF_C_PAD);
  assign we_d_pad = acc_wr && hit(addr, pcr_pkg::OFF_D_PAD);
  assign we_mask_ab = acc_wr && hit(addr, pcr_pkg::OFF_MASK_AB);
  assign we_mask_bc = acc_wr && hit(addr, pcr_pkg::OFF_MASK_BC);
  assign we_pwr_first = acc_wr && hit(addr, pcr_pkg::OFF_PWR_FIRST);
  assign we_pwr_second = acc_wr && hit(addr, pcr_pkg::OFF_PWR_SECOND);
  assign we_scan = acc_wr && hit(addr, pcr_pkg::OFF_SCAN);
  assign we_page = acc_wr && hit(addr, pcr_pkg::OFF_PAGE);
  assign we_space = acc_wr && hit(addr, pcr_pkg::OFF_SPACE);
  assign we_cells_ab = acc_wr && hit(addr, pcr_pkg::OFF_CELLS_AB);
  assign we_cells_bc = acc_wr && hit(addr, pcr_pkg::OFF_CELLS_BC);

  // writable registers; unlisted offsets fall through unchanged
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      a_mode <= pcr_pkg::RST_REG;
      b_mode <= pcr_pkg::RST_REG;
      out_r <= '{default: pcr_pkg::RST_REG};
      dir_r <= '{default: pcr_pkg::RST_REG};
      pad_r <= '{default: pcr_pkg::RST_REG};
      mask_ab <= pcr_pkg::RST_REG;
      mask_bc <= pcr_pkg::RST_REG;
      power_first <= pcr_pkg::RST_REG;
      power_second <= pcr_pkg::RST_REG;
      scan_port <= pcr_pkg::RST_REG;
      page <= pcr_pkg::RST_REG;
      space_map <= pcr_pkg::RST_REG;
    end
    else
    begin
      if (we_a_mode) a_mode <= wdata;
      if (we_b_mode) b_mode <= wdata;
      if (we_a_out) out_r[0] <= wdata;
      if (we_b_out) out_r[1] <= wdata;
      if (we_c_out) out_r[2] <= wdata;
      if (we_d_out) out_r[3] <= wdata;
      if (we_a_dir) dir_r[0] <= wdata;
      if (we_b_dir) dir_r[1] <= wdata;
      if (we_c_dir) dir_r[2] <= wdata;
      if (we_d_dir) dir_r[3] <= wdata;
      if (we_a_pad) pad_r[0] <= wdata;
      if (we_b_pad) pad_r[1] <= wdata;
      if (we_c_pad) pad_r[2] <= wdata;
      if (we_d_pad) pad_r[3] <= wdata;
      if (we_mask_ab) mask_ab <= wdata;
      if (we_mask_bc) mask_bc <= wdata;
      if (we_pwr_first) power_first <= wdata;
      if (we_pwr_second) power_second <= wdata;
      if (we_scan) scan_port <= wdata;
      if (we_page) page <= wdata;
      if (we_space) space_map <= wdata;
    end
  end

  // output cells: array logic each cycle, host write replaces unmasked bits
  assign next_cells_ab = we_cells_ab ?
    ((wdata & ~mask_ab) | (cells_ab & mask_ab)) : cells_ab_next_in;
  assign next_cells_bc = we_cells_bc ?
    ((wdata & ~mask_bc) | (cells_bc & mask_bc)) : cells_bc_next_in;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cells_ab <= pcr_pkg::RST_REG;
      cells_bc <= pcr_pkg::RST_REG;
    end
    else
    begin
      cells_ab <= next_cells_ab;
      cells_bc <= next_cells_bc;
    end
  end

  // pin drive: a mode bit set selects latched address on A and B
  assign a_oe_eff = dir_r[0] | a_mode;
  assign b_oe_eff = dir_r[1] | b_mode;
  assign c_oe_eff = dir_r[2] | cells_bc_oe;
  assign d_oe_eff = dir_r[3];

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pa_out <= pcr_pkg::RST_REG;
      pb_out <= pcr_pkg::RST_REG;
      pc_out <= pcr_pkg::RST_REG;
      pd_out <= pcr_pkg::RST_REG;
      pa_oe <= pcr_pkg::RST_REG;
      pb_oe <= pcr_pkg::RST_REG;
      pc_oe <= pcr_pkg::RST_REG;
      pd_oe <= pcr_pkg::RST_REG;
    end
    else
    begin
      pa_out <= (a_mode & latched_addr_a) | (~a_mode & out_r[0]);
      pb_out <= (b_mode & latched_addr_b) | (~b_mode & out_r[1]);
      pc_out <= out_r[2];
      pd_out <= out_r[3];
      pa_oe <= a_oe_eff | cells_ab_oe;
      pb_oe <= b_oe_eff;
      pc_oe <= c_oe_eff;
      pd_oe <= d_oe_eff;
    end
  end

  // pad type copies for the pin drivers
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pa_pad <= pcr_pkg::RST_REG;
      pb_pad <= pcr_pkg::RST_REG;
      pc_pad <= pcr_pkg::RST_REG;
      pd_pad <= pcr_pkg::RST_REG;
    end
    else
    begin
      pa_pad <= pad_r[0];
      pb_pad <= pad_r[1];
      pc_pad <= pad_r[2];
      pd_pad <= pad_r[3];
    end
  end

  // memory selects pass from decode array, unfitted blocks held off
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      main_sector_selects <= pcr_pkg::RST_REG;
      boot_sector_selects <= 4'h0;
      sram_block_select <= 1'b0;
    end
    else
    begin
      main_sector_selects <= main_sector_selects_in;
      boot_sector_selects <= BOOT_FITTED ? boot_sector_selects_in : 4'h0;
      sram_block_select <= SRAM_FITTED & sram_block_select_in;
    end
  end

  // read selection
  function automatic logic [7:0] rd_sel(input logic [7:0] a);
    case (a)
      pcr_pkg::OFF_A_PIN: rd_sel = pin_now[0];
      pcr_pkg::OFF_B_PIN: rd_sel = pin_now[1];
      pcr_pkg::OFF_C_PIN: rd_sel = pin_now[2];
      pcr_pkg::OFF_D_PIN: rd_sel = pin_now[3];
      pcr_pkg::OFF_A_MODE: rd_sel = a_mode;
      pcr_pkg::OFF_B_MODE: rd_sel = b_mode;
      pcr_pkg::OFF_A_OUT: rd_sel = out_r[0];
      pcr_pkg::OFF_B_OUT: rd_sel = out_r[1];
      pcr_pkg::OFF_C_OUT: rd_sel = out_r[2];
      pcr_pkg::OFF_D_OUT: rd_sel = out_r[3];
      pcr_pkg::OFF_A_DIR: rd_sel = dir_r[0];
      pcr_pkg::OFF_B_DIR: rd_sel = dir_r[1];
      pcr_pkg::OFF_C_DIR: rd_sel = dir_r[2];
      pcr_pkg::OFF_D_DIR: rd_sel = dir_r[3];
      pcr_pkg::OFF_A_PAD: rd_sel = pad_r[0];
      pcr_pkg::OFF_B_PAD: rd_sel = pad_r[1];
      pcr_pkg::OFF_C_PAD: rd_sel = pad_r[2];
      pcr_pkg::OFF_D_PAD: rd_sel = pad_r[3];
      pcr_pkg::OFF_A_IMC: rd_sel = input_cells_a;
      pcr_pkg::OFF_B_IMC: rd_sel = input_cells_b;
      pcr_pkg::OFF_C_IMC: rd_sel = input_cells_c;
      pcr_pkg::OFF_A_OES: rd_sel = pa_oe;
      pcr_pkg::OFF_B_OES: rd_sel = pb_oe;
      pcr_pkg::OFF_C_OES: rd_sel = pc_oe;
      pcr_pkg::OFF_D_OES: rd_sel = pd_oe;
      pcr_pkg::OFF_CELLS_AB: rd_sel = cells_ab;
      pcr_pkg::OFF_CELLS_BC: rd_sel = cells_bc;
      pcr_pkg::OFF_MASK_AB: rd_sel = mask_ab;
      pcr_pkg::OFF_MASK_BC: rd_sel = mask_bc;
      pcr_pkg::OFF_PWR_FIRST: rd_sel = power_first;
      pcr_pkg::OFF_PWR_SECOND: rd_sel = power_second;
      pcr_pkg::OFF_MAIN_LOCK: rd_sel = main_lock_in;
      pcr_pkg::OFF_BOOT_LOCK:
        rd_sel = {security_in, 3'h0, BOOT_FITTED ? boot_lock_in : 4'h0};
      pcr_pkg::OFF_SCAN: rd_sel = scan_port;
      pcr_pkg::OFF_PAGE: rd_sel = page;
      pcr_pkg::OFF_SPACE: rd_sel = space_map;
      default: rd_sel = pcr_pkg::RD_NONE;
    endcase
  endfunction

  assign mux_rd = rd_sel(addr);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata <= pcr_pkg::RD_NONE;
    else if (register_window_select && rd_stb)
      rdata <= mux_rd;
  end
endmodule

// File: hdl/pcr_pkg.sv
// pcr_pkg: offsets, widths and reset values of the port and control register block
// assumes an 8-bit host bus with byte offsets inside a 256-byte register window
package pcr_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] OFF_A_PIN = 8'h00;
  localparam logic [7:0] OFF_B_PIN = 8'h01;
  localparam logic [7:0] OFF_A_MODE = 8'h02;
  localparam logic [7:0] OFF_B_MODE = 8'h03;
  localparam logic [7:0] OFF_A_OUT = 8'h04;
  localparam logic [7:0] OFF_B_OUT = 8'h05;
  localparam logic [7:0] OFF_A_DIR = 8'h06;
  localparam logic [7:0] OFF_B_DIR = 8'h07;
  localparam logic [7:0] OFF_A_PAD = 8'h08;
  localparam logic [7:0] OFF_B_PAD = 8'h09;
  localparam logic [7:0] OFF_A_IMC = 8'h0A;
  localparam logic [7:0] OFF_B_IMC = 8'h0B;
  localparam logic [7:0] OFF_A_OES = 8'h0C;
  localparam logic [7:0] OFF_B_OES = 8'h0D;
  localparam logic [7:0] OFF_C_PIN = 8'h10;
  localparam logic [7:0] OFF_D_PIN = 8'h11;
  localparam logic [7:0] OFF_C_OUT = 8'h12;
  localparam logic [7:0] OFF_D_OUT = 8'h13;
  localparam logic [7:0] OFF_C_DIR = 8'h14;
  localparam logic [7:0] OFF_D_DIR = 8'h15;
  localparam logic [7:0] OFF_C_PAD = 8'h16;
  localparam logic [7:0] OFF_D_PAD = 8'h17;
  localparam logic [7:0] OFF_C_IMC = 8'h18;
  localparam logic [7:0] OFF_C_OES = 8'h1A;
  localparam logic [7:0] OFF_D_OES = 8'h1B;
  localparam logic [7:0] OFF_CELLS_AB = 8'h20;
  localparam logic [7:0] OFF_CELLS_BC = 8'h21;
  localparam logic [7:0] OFF_MASK_AB = 8'h22;
  localparam logic [7:0] OFF_MASK_BC = 8'h23;
  localparam logic [7:0] OFF_PWR_FIRST = 8'hB0;
  localparam logic [7:0] OFF_PWR_SECOND = 8'hB4;
  localparam logic [7:0] OFF_MAIN_LOCK = 8'hC0;
  localparam logic [7:0] OFF_BOOT_LOCK = 8'hC2;
  localparam logic [7:0] OFF_SCAN = 8'hC7;
  localparam logic [7:0] OFF_PAGE = 8'hE0;
  localparam logic [7:0] OFF_SPACE = 8'hE2;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RD_NONE = 8'h00;
endpackage

// File: dv/pcr_regs_sva.sv
// pcr_regs_sva: port-level checks of the register block
// assumes one clock and an async active-low reset
`timescale 1ns/1ps
module pcr_regs_sva (
  // watched ports
  input wire logic clk,
  input wire logic rstn,
  input wire logic register_window_select,
  input wire logic [7:0] addr,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic [7:0] pa_oe,
  input wire logic [7:0] main_sector_selects_in,
  input wire logic [7:0] main_sector_selects,
  input wire logic [7:0] main_lock_in,
  input wire logic [3:0] boot_lock_in,
  input wire logic security_in,
  input wire logic [7:0] power_first,
  input wire logic [7:0] power_second,
  input wire logic [7:0] page,
  input wire logic [7:0] space_map
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire wr = register_window_select && wr_stb;
  wire rd = register_window_select && rd_stb;
  a_page_write: assert property (wr && addr == 8'hE0 |=> page == $past(wdata))
    else $error("page not loaded");
  a_space_write: assert property (wr && addr == 8'hE2 |=> space_map == $past(wdata))
    else $error("space map not loaded");
  a_pwr1_write: assert property (wr && addr == 8'hB0 |=> power_first == $past(wdata))
    else $error("first power reg not loaded");
  a_pwr2_write: assert property (wr && addr == 8'hB4 |=> power_second == $past(wdata))
    else $error("second power reg not loaded");
  a_unselected_hold: assert property (!register_window_select |=>
    $stable(page) && $stable(space_map) && $stable(power_first))
    else $error("register changed without select");
  a_unlisted_read: assert property (rd && addr == 8'hFF |=> rdata == 8'h00)
    else $error("unlisted read not zero");
  a_main_lock: assert property (rd && addr == 8'hC0 |=> rdata == $past(main_lock_in))
    else $error("main lock read wrong");
  a_boot_lock: assert property (rd && addr == 8'hC2 |=>
    rdata == {$past(security_in), 3'h0, $past(boot_lock_in)})
    else $error("boot lock read wrong");
  a_oe_status: assert property (rd && addr == 8'h0C |=> rdata == $past(pa_oe))
    else $error("enable status read wrong");
  a_sel_follow: assert property ($past(rstn) |->
    main_sector_selects == $past(main_sector_selects_in))
    else $error("sector selects lag wrong");
endmodule
bind pcr_regs pcr_regs_sva i_pcr_regs_sva (.*);

// File: dv/pcr_host.sv
// pcr_host: host bus model for the register window
// assumes one-cycle strobes timed by clk
`timescale 1ns/1ps
module pcr_host (
  // bus side
  input wire logic clk,
  output logic register_window_select,
  output logic [7:0] addr,
  output logic wr_stb,
  output logic rd_stb,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  initial {register_window_select, wr_stb, rd_stb, addr, wdata} = '0;
  // one access at an offset inside the chosen 256-byte window
  task automatic acc(input bit s, input bit w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    register_window_select <= s;
    addr <= a;
    wdata <= d;
    wr_stb <= w;
    rd_stb <= !w;
    @(posedge clk);
    register_window_select <= 1'b0;
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
endmodule

// File: dv/pcr_regs_tb_top.sv
// pcr_regs_tb_top: self-checking bench for the register block
// assumes host model and checker are compiled first
`timescale 1ns/1ps
module pcr_regs_tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic register_window_select, wr_stb, rd_stb, security_in, sram_block_select_in;
  logic sram_block_select;
  logic [7:0] addr, wdata, rdata, pa_in, pb_in, pc_in, pd_in, pa_out, pb_out, pc_out, pd_out;
  logic [7:0] pa_oe, pb_oe, pc_oe, pd_oe, pa_pad, pb_pad, pc_pad, pd_pad, cells_ab, cells_bc;
  logic [7:0] latched_addr_a, latched_addr_b, input_cells_a, input_cells_b, input_cells_c;
  logic [7:0] cells_ab_next_in, cells_bc_next_in, cells_ab_oe, cells_bc_oe, main_lock_in;
  logic [7:0] main_sector_selects_in, main_sector_selects, power_first, power_second;
  logic [7:0] scan_port, page, space_map;
  logic [3:0] boot_sector_selects_in, boot_sector_selects, boot_lock_in;
  int miscompares = 0;
  int checks = 0;
  // offset, write data, expected readback
  logic [23:0] rows [21] = '{24'h02A5A5, 24'h035A5A, 24'h043C3C, 24'h05C3C3, 24'h06FFFF,
    24'h070F0F, 24'h08F0F0, 24'h098181, 24'h124242, 24'h132424, 24'h141818, 24'h15E7E7,
    24'h169999, 24'h176666, 24'h220F0F, 24'h23F0F0, 24'hB01111, 24'hB42222, 24'hC70101,
    24'hE0FEFE, 24'hE20707};
  always #2 clk = ~clk;
  pcr_regs i_pcr_regs (.*);
  pcr_host i_pcr_host (.*);
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_pcr_host.acc(1'b1, 1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    i_pcr_host.acc(1'b1, 1'b0, a, 8'h00);
    #1 chk(n, rdata, e);
  endtask
  task automatic close_out;
    if (miscompares == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #40000;
    miscompares++;
    close_out();
  end
  initial
  begin
    {pa_in, pb_in, pc_in, pd_in, latched_addr_a, latched_addr_b, input_cells_a} = '0;
    {input_cells_b, input_cells_c, cells_ab_next_in, cells_bc_next_in, cells_ab_oe} = '0;
    {cells_bc_oe, main_sector_selects_in, main_lock_in, boot_sector_selects_in} = '0;
    {boot_lock_in, security_in, sram_block_select_in} = '0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    #1 chk("page", page, 8'h00);
    foreach (rows[i])
    begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0], "readback");
    end
    @(posedge clk);
    latched_addr_a <= 8'hFF;
    repeat (3) @(posedge clk);
    #1 chk("pa_out", pa_out, 8'hBD);
    chk("pa_oe", pa_oe, 8'hFF);
    rd(8'h0C, 8'hFF, "oe_status");
    @(posedge clk);
    latched_addr_a <= 8'h00;
    {pa_in, pd_in, input_cells_a, cells_ab_next_in, cells_bc_next_in} <= 40'h96113C5A77;
    {main_sector_selects_in, main_lock_in, boot_lock_in, security_in} <= {16'h816C, 4'h9, 1'b1};
    {pb_in, pc_in, latched_addr_b, input_cells_b, input_cells_c} <= 40'h0102030405;
    {boot_sector_selects_in, sram_block_select_in} <= {4'h9, 1'b1};
    repeat (6) @(posedge clk);
    #1 chk("pa_out", pa_out, 8'h18);
    chk("main_sel", main_sector_selects, 8'h81);
    chk("boot_sel", {3'h0, sram_block_select, boot_sector_selects}, 8'h19);
    rd(8'h00, 8'h96, "pin_a");
    rd(8'h11, 8'h11, "pin_d");
    fork
      i_pcr_host.acc(1'b1, 1'b1, 8'h20, 8'hC3);
      begin
        repeat (2) @(posedge clk);
        #1 chk("cells_ab", cells_ab, 8'hCA);
      end
    join
    rd(8'h20, 8'h5A, "cells_ab_rd");
    rd(8'h21, 8'h77, "cells_bc_rd");
    wr(8'hC0, 8'hFF);
    rd(8'hC0, 8'h6C, "main_lock");
    rd(8'hC2, 8'h89, "boot_lock");
    wr(8'hFF, 8'h77);
    rd(8'hFF, 8'h00, "unlisted");
    i_pcr_host.acc(1'b0, 1'b1, 8'hE0, 8'h00);
    rd(8'hE0, 8'hFE, "page_kept");
    @(posedge clk);
    cells_ab_oe <= 8'h40;
    cells_bc_oe <= 8'h21;
    wr(8'h06, 8'h00);
    rd(8'h0C, 8'hE5, "oe_a");
    rd(8'h0D, 8'h5F, "oe_b");
    rd(8'h1A, 8'h39, "oe_c");
    rd(8'h1B, 8'hE7, "oe_d");
    rd(8'h0A, 8'h3C, "in_cells_a");
    rd(8'h0B, 8'h04, "in_cells_b");
    rd(8'h18, 8'h05, "in_cells_c");
    rd(8'h10, 8'h02, "pin_c");
    chk("pb_out", pb_out, 8'h83);
    chk("pc_out", pc_out, 8'h42);
    chk("pd_out", pd_out, 8'h24);
    chk("pc_oe", pc_oe, 8'h39);
    chk("pd_oe", pd_oe, 8'hE7);
    chk("pa_pad", pa_pad, 8'hF0);
    chk("pb_pad", pb_pad, 8'h81);
    chk("pc_pad", pc_pad, 8'h99);
    chk("pd_pad", pd_pad, 8'h66);
    chk("power_first", power_first, 8'h11);
    chk("power_second", power_second, 8'h22);
    chk("space_map", space_map, 8'h07);
    chk("scan_port", scan_port, 8'h01);
    wr(8'h21, 8'h0F);
    #1 chk("cells_bc", cells_bc, 8'h7F);
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    #1 chk("rst_page", page, 8'h00);
    chk("rst_pa_oe", pa_oe, 8'h00);
    chk("rst_cells", cells_ab, 8'h00);
    chk("rst_rdata", rdata, 8'h00);
    @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1 chk("cells_after_rst", cells_ab, 8'h5A);
    chk("pa_oe_after_rst", pa_oe, 8'h40);
    rd(8'h02, 8'h00, "mode_after_rst");
    close_out();
  end
endmodule
